// file: design/ddr3_bank_burst_selfrefresh.sv
// Command FIFO and DDR3 bank, burst and self-refresh temperature logic.
// Commands come from same-clock controller logic; temp_hot_pin is asynchronous.
//
// Implementation choices: the register addresses and strobed register access.
`timescale 1ns/1ps
`default_nettype none

module cmd_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output var  logic             in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output var  logic             out_valid,
  input  wire logic             out_ready,
  output var  logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr_reg;
  logic [PW-1:0]    rd_ptr_reg;
  logic [CW-1:0]    count_reg;
  logic [CW-1:0]    count_next;
  logic             push;
  logic             pop;

  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_valid = (count_reg != '0);
  assign out_data  = mem[rd_ptr_reg];

  always_comb
  begin
    count_next = count_reg;
    if (push && !pop)
      count_next = count_reg + CW'(1);
    else if (pop && !push)
      count_next = count_reg - CW'(1);
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      count_reg  <= '0;
      in_ready   <= 1'b0;
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end
    else
    begin
      count_reg <= count_next;
      // Registered ready keeps the top output straight from a flop
      in_ready  <= (count_next != CW'(DEPTH));
      if (push)
        wr_ptr_reg <= (wr_ptr_reg == PW'(DEPTH - 1)) ? '0 : wr_ptr_reg + PW'(1);
      if (pop)
        rd_ptr_reg <= (rd_ptr_reg == PW'(DEPTH - 1)) ? '0 : rd_ptr_reg + PW'(1);
    end
  end

  always_ff @(posedge clk)
  begin
    if (push)
      mem[wr_ptr_reg] <= in_data;
  end
endmodule : cmd_fifo

module ddr3_bank_burst_selfrefresh #(
  parameter int FIFO_DEPTH = ddr3_pkg::FIFO_DEPTH
) (
  input  wire logic                                 clk,
  input  wire logic                                 rst_n,
  input  wire logic                                 cmd_valid,
  output var  logic                                 cmd_ready,
  input  wire ddr3_pkg::cmd_type                    cmd,
  input  wire logic                                 temp_hot_pin,
  input  wire logic [ddr3_pkg::REG_ADDR_W-1:0]      reg_addr,
  input  wire logic [31:0]                          reg_wdata,
  input  wire logic                                 reg_wr,
  input  wire logic                                 reg_rd,
  output var  logic [31:0]                          reg_rdata,
  output var  logic                                 beat_valid,
  output var  ddr3_pkg::beat_type                   beat,
  output var  logic                                 refresh_tick,
  output var  logic                                 refresh_rate_hi
);
  localparam int NB = ddr3_pkg::NUM_BANKS;
  localparam int TW = 3;

  ddr3_pkg::cmd_type         head;
  logic                      head_valid;
  logic                      accept;
  logic                      can_issue;
  logic                      bad_cmd;
  logic [NB-1:0]             open_vec;
  logic [NB-1:0]             busy_vec;
  logic [NB-1:0]             ap_hit;
  logic [NB-1:0]             pre_hit;
  logic [NB-1:0]             act_hit;
  logic                      head_open;
  logic                      head_busy;
  logic                      burst_free;
  logic                      burst_start;
  logic                      eight_sel;
  logic                      last_beat;
  logic                      auto_mode;
  logic                      err_set;
  logic                      err_clr;
  logic [31:0]               rd_mux;
  logic [11:0]               refi_cnt_reg;
  logic [11:0]               refi_limit;
  logic                      temp_s1_reg;
  logic                      temp_s2_reg;
  logic                      temp_s3_reg;
  logic                      temp_hot_reg;
  logic [1:0]                mr0_bl_reg;
  logic                      mr2_asr_reg;
  logic                      mr2_srt_reg;
  logic                      asr_supported_reg;
  logic                      ext_supported_reg;
  logic                      sr_active_reg;
  logic                      err_reg;
  ddr3_pkg::burst_state_type burst_state_reg;
  logic [2:0]                beat_idx_reg;
  logic                      len_eight_reg;
  logic                      ap_pending_reg;
  logic                      is_write_reg;
  logic [ddr3_pkg::BANK_W-1:0] burst_bank_reg;
  logic [ddr3_pkg::COL_W-1:0]  col_base_reg;
  logic                      open_reg [NB];
  logic [ddr3_pkg::ADDR_W-1:0] row_reg [NB];
  logic [TW-1:0]             trp_cnt_reg [NB];

  cmd_fifo #(
    .WIDTH ($bits(ddr3_pkg::cmd_type)),
    .DEPTH (FIFO_DEPTH)
  ) u_cmd_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (cmd_valid),
    .in_ready  (cmd_ready),
    .in_data   (cmd),
    .out_valid (head_valid),
    .out_ready (accept),
    .out_data  (head)
  );

  assign head_open  = open_vec[head.bank] && !ap_hit[head.bank];
  assign head_busy  = busy_vec[head.bank];
  assign last_beat  = (beat_idx_reg == (len_eight_reg ? 3'h7 : 3'h3));
  assign burst_free = (burst_state_reg == ddr3_pkg::BURST_IDLE) || last_beat;
  assign eight_sel  = (mr0_bl_reg == ddr3_pkg::BL_FIXED_EIGHT) ||
                      ((mr0_bl_reg == ddr3_pkg::BL_ON_THE_FLY) && head.addr[ddr3_pkg::A_BURST_SEL]);
  assign auto_mode  = mr2_asr_reg && !mr2_srt_reg && asr_supported_reg;

  // Data-path stalls keep transfers whole; the FIFO absorbs the wait
  always_comb
  begin
    can_issue = 1'b1;
    bad_cmd   = 1'b0;
    if (sr_active_reg)
      bad_cmd = (head.op != ddr3_pkg::OP_SRX) && (head.op != ddr3_pkg::OP_NOP);
    else
    begin
      case (head.op)
        ddr3_pkg::OP_ACT:
        begin
          can_issue = !head_busy;
          bad_cmd   = open_vec[head.bank];
        end
        ddr3_pkg::OP_RD, ddr3_pkg::OP_WR:
        begin
          can_issue = burst_free;
          bad_cmd   = !head_open;
        end
        default:
        begin
          can_issue = 1'b1;
          bad_cmd   = 1'b0;
        end
      endcase
    end
  end

  assign accept      = head_valid && can_issue;
  assign err_set     = accept && bad_cmd;
  // Other-bank access starts beside a precharge
  assign burst_start = accept && !bad_cmd && !sr_active_reg &&
                       ((head.op == ddr3_pkg::OP_RD) || (head.op == ddr3_pkg::OP_WR));

  generate
    for (genvar b = 0; b < NB; b++)
    begin : g_bank
      localparam logic [ddr3_pkg::BANK_W-1:0] BANK_SEL = (ddr3_pkg::BANK_W)'(b);
      assign pre_hit[b]  = accept && !sr_active_reg && ((head.op == ddr3_pkg::OP_PREA) ||
                           ((head.op == ddr3_pkg::OP_PRE) && (head.bank == BANK_SEL)));
      assign act_hit[b]  = accept && !bad_cmd && !sr_active_reg &&
                           (head.op == ddr3_pkg::OP_ACT) && (head.bank == BANK_SEL);
      assign ap_hit[b]   = (burst_state_reg == ddr3_pkg::BURST_RUN) && last_beat &&
                           ap_pending_reg && (burst_bank_reg == BANK_SEL);
      assign open_vec[b] = open_reg[b];
      assign busy_vec[b] = (trp_cnt_reg[b] != '0);

      always_ff @(posedge clk)
      begin
        if (!rst_n)
        begin
          open_reg[b]    <= 1'b0;
          row_reg[b]     <= '0;
          trp_cnt_reg[b] <= '0;
        end
        else if (pre_hit[b] || ap_hit[b])
        begin
          open_reg[b]    <= 1'b0;
          trp_cnt_reg[b] <= TW'(ddr3_pkg::TRP_CYCLES);
        end
        else if (act_hit[b])
        begin
          open_reg[b] <= 1'b1;
          row_reg[b]  <= head.addr;
        end
        else if (trp_cnt_reg[b] != '0)
          trp_cnt_reg[b] <= trp_cnt_reg[b] - TW'(1);
      end
    end
  endgenerate

  // Mode register loads
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      mr0_bl_reg  <= ddr3_pkg::MR0_BL_RESET;
      mr2_asr_reg <= 1'b0;
      mr2_srt_reg <= 1'b0;
    end
    else if (accept && !sr_active_reg && (head.op == ddr3_pkg::OP_MRS))
    begin
      if (head.bank == ddr3_pkg::MR0_SEL)
        mr0_bl_reg <= head.addr[ddr3_pkg::A_BL_LSB +: 2];
      if (head.bank == ddr3_pkg::MR2_SEL)
      begin
        mr2_asr_reg <= head.addr[ddr3_pkg::A_AUTO_SR];
        mr2_srt_reg <= head.addr[ddr3_pkg::A_MANUAL_SRT];
      end
    end
  end

  // Burst engine
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      burst_state_reg <= ddr3_pkg::BURST_IDLE;
      beat_idx_reg    <= '0;
      len_eight_reg   <= 1'b0;
      ap_pending_reg  <= 1'b0;
      is_write_reg    <= 1'b0;
      burst_bank_reg  <= '0;
      col_base_reg    <= '0;
    end
    else if (burst_start)
    begin
      burst_state_reg <= ddr3_pkg::BURST_RUN;
      beat_idx_reg    <= '0;
      len_eight_reg   <= eight_sel;
      ap_pending_reg  <= head.addr[ddr3_pkg::A_AUTO_PRE];
      is_write_reg    <= (head.op == ddr3_pkg::OP_WR);
      burst_bank_reg  <= head.bank;
      // Column skips the auto-precharge bit A10
      col_base_reg    <= {head.addr[11], head.addr[9:0]};
    end
    else
    begin
      case (burst_state_reg)
        ddr3_pkg::BURST_RUN:
        begin
          beat_idx_reg <= beat_idx_reg + 3'h1;
          if (last_beat)
            burst_state_reg <= ddr3_pkg::BURST_IDLE;
        end
        default:
          beat_idx_reg <= '0;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      beat_valid <= 1'b0;
      beat       <= '0;
    end
    else
    begin
      beat_valid    <= (burst_state_reg == ddr3_pkg::BURST_RUN);
      beat.bank     <= burst_bank_reg;
      beat.col      <= {col_base_reg[ddr3_pkg::COL_W-1:3], col_base_reg[2:0] + beat_idx_reg};
      beat.is_write <= is_write_reg;
      beat.last     <= (burst_state_reg == ddr3_pkg::BURST_RUN) && last_beat;
    end
  end

  // Three-stage sampling of the temperature pin
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      temp_s1_reg  <= 1'b0;
      temp_s2_reg  <= 1'b0;
      temp_s3_reg  <= 1'b0;
      temp_hot_reg <= 1'b0;
    end
    else
    begin
      temp_s1_reg <= temp_hot_pin;
      temp_s2_reg <= temp_s1_reg;
      temp_s3_reg <= temp_s2_reg;
      if (temp_s2_reg == temp_s3_reg)
        temp_hot_reg <= temp_s3_reg;
    end
  end

  // Self-refresh state and refresh timer
  assign refi_limit = refresh_rate_hi ? 12'(ddr3_pkg::REFI_EXT_CYC - 1) : 12'(ddr3_pkg::REFI_NORMAL_CYC - 1);

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      sr_active_reg   <= 1'b0;
      refi_cnt_reg    <= '0;
      refresh_tick    <= 1'b0;
      refresh_rate_hi <= 1'b0;
    end
    else
    begin
      if (accept && (head.op == ddr3_pkg::OP_SRE) && !sr_active_reg)
        sr_active_reg <= 1'b1;
      else if (accept && (head.op == ddr3_pkg::OP_SRX))
        sr_active_reg <= 1'b0;
      // Manual bit fixes the rate
      // Auto on a normal-range part never doubles the rate
      refresh_rate_hi <= auto_mode ? (temp_hot_reg && ext_supported_reg) : mr2_srt_reg;
      refresh_tick    <= sr_active_reg && (refi_cnt_reg >= refi_limit);
      if (!sr_active_reg || (refi_cnt_reg >= refi_limit))
        refi_cnt_reg <= '0;
      else
        refi_cnt_reg <= refi_cnt_reg + 12'h1;
    end
  end

  // Register bus
  assign err_clr = reg_wr && (reg_addr == ddr3_pkg::STATUS_OFS) && reg_wdata[ddr3_pkg::STAT_ERR_BIT];

  always_comb
  begin
    rd_mux = '0;
    case (reg_addr)
      ddr3_pkg::STATUS_OFS:
      begin
        rd_mux[ddr3_pkg::STAT_OPEN_LSB +: NB] = open_vec;
        rd_mux[ddr3_pkg::STAT_SR_BIT]         = sr_active_reg;
        rd_mux[ddr3_pkg::STAT_AUTO_BIT]       = auto_mode;
        rd_mux[ddr3_pkg::STAT_RATE_BIT]       = refresh_rate_hi;
        rd_mux[ddr3_pkg::STAT_ERR_BIT]        = err_reg;
      end
      ddr3_pkg::CONFIG_OFS:
      begin
        rd_mux[ddr3_pkg::CFG_ASR_BIT] = asr_supported_reg;
        rd_mux[ddr3_pkg::CFG_EXT_BIT] = ext_supported_reg;
      end
      ddr3_pkg::MODE_OFS:
      begin
        rd_mux[ddr3_pkg::MODE_BL_LSB +: 2]  = mr0_bl_reg;
        rd_mux[ddr3_pkg::MODE_ASR_BIT]      = mr2_asr_reg;
        rd_mux[ddr3_pkg::MODE_SRT_BIT]      = mr2_srt_reg;
      end
      default:
        rd_mux = '0;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      reg_rdata         <= '0;
      err_reg           <= 1'b0;
      asr_supported_reg <= ddr3_pkg::CFG_ASR_RESET;
      ext_supported_reg <= ddr3_pkg::CFG_EXT_RESET;
    end
    else
    begin
      reg_rdata <= reg_rd ? rd_mux : '0;
      // Set wins over a clear in the same cycle
      if (err_set)
        err_reg <= 1'b1;
      else if (err_clr)
        err_reg <= 1'b0;
      if (reg_wr && (reg_addr == ddr3_pkg::CONFIG_OFS))
      begin
        asr_supported_reg <= reg_wdata[ddr3_pkg::CFG_ASR_BIT];
        ext_supported_reg <= reg_wdata[ddr3_pkg::CFG_EXT_BIT];
      end
    end
  end

  sequence s_chop_start;
    burst_start && !eight_sel;
  endsequence
  sequence s_four_beats;
    beat_valid [*4] ##0 beat.last;
  endsequence

  a_act_opens_row: assert property (@(posedge clk) disable iff (!rst_n)
    act_hit[0] |=> open_reg[0] && row_reg[0] == $past(head.addr))
    else $error("activate did not open bank 0");
  a_pre_closes: assert property (@(posedge clk) disable iff (!rst_n)
    (accept && head.op == ddr3_pkg::OP_PREA && !sr_active_reg) |=> open_vec == '0)
    else $error("all-bank precharge left a bank open");
  a_pre_restarts: assert property (@(posedge clk) disable iff (!rst_n)
    pre_hit[1] |=> trp_cnt_reg[1] == TW'(ddr3_pkg::TRP_CYCLES))
    else $error("precharge period not restarted");
  a_idle_pre_ok: assert property (@(posedge clk) disable iff (!rst_n)
    (pre_hit[2] && !open_reg[2] && !err_reg && !err_clr) |=> !err_reg)
    else $error("idle precharge flagged as error");
  a_chop_len: assert property (@(posedge clk) disable iff (!rst_n)
    s_chop_start |-> ##2 s_four_beats)
    else $error("chopped burst not four beats");
  a_eight_len: assert property (@(posedge clk) disable iff (!rst_n)
    (burst_start && eight_sel) |-> ##2 (beat_valid && !beat.last) [*7] ##1 beat.last)
    else $error("eight beat burst wrong length");
  a_col_no_sel: assert property (@(posedge clk) disable iff (!rst_n)
    burst_start |-> ##2 beat.col[10:3] == $past({head.addr[11], head.addr[9:3]}, 2))
    else $error("column took the burst select bit");
  a_auto_rate: assert property (@(posedge clk) disable iff (!rst_n)
    (auto_mode && ext_supported_reg) |=> refresh_rate_hi == $past(temp_hot_reg))
    else $error("auto rate ignores temperature");
  a_manual_rate: assert property (@(posedge clk) disable iff (!rst_n)
    !auto_mode |=> refresh_rate_hi == $past(mr2_srt_reg))
    else $error("manual rate ignores range bit");
  a_auto_enable: assert property (@(posedge clk) disable iff (!rst_n)
    (accept && head.op == ddr3_pkg::OP_MRS && head.bank == ddr3_pkg::MR2_SEL && !sr_active_reg &&
     head.addr[6] && !head.addr[7] && asr_supported_reg) |=> auto_mode)
    else $error("auto mode not entered");
  a_ap_other_bank: assert property (@(posedge clk) disable iff (!rst_n)
    ((|ap_hit) && head_valid && !sr_active_reg && head.op == ddr3_pkg::OP_RD &&
     !ap_hit[head.bank] && open_vec[head.bank]) |-> accept && burst_start)
    else $error("other-bank read refused during auto precharge");

endmodule : ddr3_bank_burst_selfrefresh

`default_nettype wire

// file: design/ddr3_pkg.sv
// Package for the DDR3 bank, burst and self-refresh command model.
// Assumes a 200 MHz clk; every user of these names qualifies them with the package.
package ddr3_pkg;

  localparam int NUM_BANKS     = 8;
  localparam int BANK_W        = 3;
  localparam int ADDR_W        = 16;
  localparam int COL_W         = 11;
  localparam int REG_ADDR_W    = 8;

  // Register offsets
  localparam logic [7:0] STATUS_OFS = 8'h00;
  localparam logic [7:0] CONFIG_OFS = 8'h04;
  localparam logic [7:0] MODE_OFS   = 8'h08;

  // Field positions
  localparam int STAT_OPEN_LSB  = 0;
  localparam int STAT_SR_BIT    = 8;
  localparam int STAT_AUTO_BIT  = 9;
  localparam int STAT_RATE_BIT  = 10;
  localparam int STAT_ERR_BIT   = 12;
  localparam int CFG_ASR_BIT    = 0;
  localparam int CFG_EXT_BIT    = 1;
  localparam int MODE_BL_LSB    = 0;
  localparam int MODE_ASR_BIT   = 2;
  localparam int MODE_SRT_BIT   = 3;

  // Command address bits
  localparam int A_BL_LSB       = 0;
  localparam int A_AUTO_SR      = 6;
  localparam int A_MANUAL_SRT   = 7;
  localparam int A_AUTO_PRE     = 10;
  localparam int A_BURST_SEL    = 12;

  // Mode register select on the bank inputs
  localparam logic [2:0] MR0_SEL = 3'h0;
  localparam logic [2:0] MR2_SEL = 3'h2;

  // Burst field encodings
  localparam logic [1:0] BL_FIXED_EIGHT = 2'h0;
  localparam logic [1:0] BL_ON_THE_FLY  = 2'h1;

  // Reset values
  localparam logic [1:0] MR0_BL_RESET = 2'h0;
  localparam logic       CFG_ASR_RESET = 1'b1;
  localparam logic       CFG_EXT_RESET = 1'b1;

  // Timing
  localparam int CLK_PERIOD_PS   = 5000;
  localparam int TRP_PS          = 13750;
  localparam int TRP_CYCLES      = (TRP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int REFI_NORMAL_NS  = 7800;
  localparam int REFI_EXT_NS     = 3900;
  localparam int REFI_NORMAL_CYC = REFI_NORMAL_NS * 1000 / CLK_PERIOD_PS;
  localparam int REFI_EXT_CYC    = REFI_EXT_NS * 1000 / CLK_PERIOD_PS;
  localparam int BEATS_CHOP      = 4;
  localparam int BEATS_EIGHT     = 8;
  localparam int FIFO_DEPTH      = 32;

  typedef enum logic [3:0] {
    OP_NOP, OP_ACT, OP_PRE, OP_PREA, OP_RD, OP_WR, OP_MRS, OP_SRE, OP_SRX
  } cmd_op_type;

  typedef struct packed {
    cmd_op_type          op;
    logic [BANK_W-1:0]   bank;
    logic [ADDR_W-1:0]   addr;
  } cmd_type;

  typedef struct packed {
    logic [BANK_W-1:0]   bank;
    logic [COL_W-1:0]    col;
    logic                is_write;
    logic                last;
  } beat_type;

  typedef enum logic {BURST_IDLE, BURST_RUN} burst_state_type;

endpackage : ddr3_pkg

// file: tb/ddr3_bank_burst_selfrefresh_tb.sv
// Self-checking bench for the bank, burst and self-refresh block.
// Assumes the controller model and the design package are compiled first.
`timescale 1ns/1ps
`default_nettype none

module ddr3_bank_burst_selfrefresh_tb;
  logic              clk = 1'b0, rst_n = 1'b0, req_valid = 1'b0, req_done, temp_hot_pin = 1'b0;
  logic              cmd_valid, cmd_ready, reg_wr = 1'b0, reg_rd = 1'b0, beat_valid, rate_hi, tick;
  logic [7:0]        reg_addr = 8'h00;
  logic [31:0]       reg_wdata = 32'h0, reg_rdata, rd_d;
  logic [15:0]       a;
  ddr3_pkg::cmd_type req = '0, cmd;
  ddr3_pkg::beat_type beat;
  int                error_cnt = 0, n_tests = 0, n;

  always #2.5 clk = ~clk;

  ddr3_ctrl_model i_ctrl (.clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req(req), .req_done(req_done),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd));
  ddr3_bank_burst_selfrefresh #(.FIFO_DEPTH(32)) i_dut (.clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd(cmd), .temp_hot_pin(temp_hot_pin), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .beat_valid(beat_valid), .beat(beat),
    .refresh_tick(tick), .refresh_rate_hi(rate_hi));

  task automatic wrap_up();
    $display("compares %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : wrap_up

  task automatic check(input logic ok, input string msg);
    n_tests++;
    if (ok !== 1'b1)
    begin
      error_cnt++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask : check

  task automatic send(input ddr3_pkg::cmd_op_type op, input logic [2:0] b, input logic [15:0] ad);
    int i;
    @(posedge clk);
    req       <= '{op, b, ad};
    req_valid <= 1'b1;
    for (i = 0; i < 60 && req_done !== 1'b1; i++)
      @(posedge clk);
    req_valid <= 1'b0;
    if (i == 60)
    begin
      check(1'b0, "command never taken");
      wrap_up();
    end
  endtask : send

  task automatic reg_write(input logic [7:0] ad, input logic [31:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= ad;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : reg_write

  // Waits first so queued commands have taken effect
  task automatic reg_read(input logic [7:0] ad);
    repeat (4) @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= ad;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    rd_d = reg_rdata;
    @(posedge clk);
    check(reg_rdata === 32'h0, "read data stands one cycle");
  endtask : reg_read

  // Beat count, burst ends and column walk of a burst starting at column address ad
  task automatic expect_beats(input int nb, input int bursts, input logic [15:0] ad, input logic wr);
    logic [10:0] base;
    int          cnt, lasts;
    base  = {ad[11], ad[9:0]};
    cnt   = 0;
    lasts = 0;
    repeat (60)
    begin
      @(posedge clk);
      if (beat_valid === 1'b1)
      begin
        if (bursts == 1)
          check(beat.col === {base[10:3], base[2:0] + 3'(cnt)} && beat.is_write === wr, "beat column");
        cnt++;
        lasts += (beat.last === 1'b1);
      end
    end
    check(cnt == nb && lasts == bursts, "beat count");
  endtask : expect_beats

  // Rate the rules ask for, given the mode bits that reach the block
  function automatic logic exp_rate(input logic a6, input logic a7, input logic hot);
    return (a6 && !a7) ? hot : a7;
  endfunction : exp_rate

  function automatic int exp_ticks(input logic hi, input int cycles);
    return cycles / (hi ? ddr3_pkg::REFI_EXT_CYC : ddr3_pkg::REFI_NORMAL_CYC);
  endfunction : exp_ticks

  initial
  begin
    void'($urandom(70350));
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    reg_read(ddr3_pkg::CONFIG_OFS);
    check(rd_d === 32'h3, "config reset");
    reg_write(ddr3_pkg::MODE_OFS, 32'hf);
    reg_write(8'h40, 32'hffff_ffff);
    reg_read(ddr3_pkg::MODE_OFS);
    check(rd_d === 32'h0, "mode read only");
    reg_read(8'h40);
    check(rd_d === 32'h0, "unmapped read");
    $display("test registers done");
    for (int f = 0; f < 2; f++)
    begin
      send(ddr3_pkg::OP_MRS, ddr3_pkg::MR0_SEL, 16'(f));
      send(ddr3_pkg::OP_ACT, 3'h0, 16'($urandom));
      for (int k = 0; k < 4; k++)
      begin
        a = 16'($urandom) & 16'h0bff;
        a[ddr3_pkg::A_BURST_SEL] = k[0];
        n = (f == 0 || k[0]) ? 8 : 4;
        fork
          send(k[1] ? ddr3_pkg::OP_WR : ddr3_pkg::OP_RD, 3'h0, a);
          expect_beats(n, 1, a, k[1]);
        join
      end
      send(ddr3_pkg::OP_PRE, 3'h0, 16'h0);
    end
    $display("test bursts done");
    send(ddr3_pkg::OP_ACT, 3'h2, 16'h1234);
    send(ddr3_pkg::OP_ACT, 3'h5, 16'h0042);
    reg_read(ddr3_pkg::STATUS_OFS);
    check(rd_d[7:0] === 8'h24, "banks open");
    send(ddr3_pkg::OP_PRE, 3'h2, 16'h0);
    send(ddr3_pkg::OP_PRE, 3'h2, 16'h0);
    reg_read(ddr3_pkg::STATUS_OFS);
    check(rd_d[7:0] === 8'h20 && rd_d[ddr3_pkg::STAT_ERR_BIT] === 1'b0, "precharge idle bank");
    send(ddr3_pkg::OP_PREA, 3'h0, 16'h0);
    reg_read(ddr3_pkg::STATUS_OFS);
    check(rd_d[7:0] === 8'h00, "precharge all");
    // Read to an idle bank is dropped and flagged until cleared
    send(ddr3_pkg::OP_RD, 3'h6, 16'h0);
    reg_read(ddr3_pkg::STATUS_OFS);
    check(rd_d[ddr3_pkg::STAT_ERR_BIT] === 1'b1, "idle bank read flagged");
    reg_write(ddr3_pkg::STATUS_OFS, 32'h1 << ddr3_pkg::STAT_ERR_BIT);
    reg_read(ddr3_pkg::STATUS_OFS);
    check(rd_d[ddr3_pkg::STAT_ERR_BIT] === 1'b0, "error cleared");
    $display("test banks done");
    send(ddr3_pkg::OP_ACT, 3'h1, 16'h0007);
    send(ddr3_pkg::OP_ACT, 3'h4, 16'h0009);
    fork
      begin
        send(ddr3_pkg::OP_RD, 3'h1, 16'h0400);
        send(ddr3_pkg::OP_RD, 3'h4, 16'h0010);
      end
      expect_beats(8, 2, 16'h0, 1'b0);
    join
    reg_read(ddr3_pkg::STATUS_OFS);
    check(rd_d[7:0] === 8'h10 && rd_d[ddr3_pkg::STAT_ERR_BIT] === 1'b0, "auto precharge");
    send(ddr3_pkg::OP_PRE, 3'h4, 16'h0);
    $display("test auto precharge done");
    for (int i = 0; i < 4; i++)
    begin
      send(ddr3_pkg::OP_MRS, ddr3_pkg::MR2_SEL, 16'(i) << ddr3_pkg::A_AUTO_SR);
      temp_hot_pin <= i[0] ^ i[1];
      reg_read(ddr3_pkg::STATUS_OFS);
      check(rd_d[ddr3_pkg::STAT_AUTO_BIT] === i[0], "auto temp mode");
      send(ddr3_pkg::OP_SRE, 3'h0, 16'h0);
      n = 0;
      // Window long enough for two fast or one slow refresh
      repeat (2000)
      begin
        @(posedge clk);
        n += int'(tick === 1'b1);
      end
      check(rate_hi === exp_rate(i[0], i[1] && !i[0], i[0] ^ i[1]), "refresh rate");
      check(n == exp_ticks(exp_rate(i[0], i[1] && !i[0], i[0] ^ i[1]), 2000), "refresh ticks");
      send(ddr3_pkg::OP_SRX, 3'h0, 16'h0);
    end
    $display("test self refresh done");
    wrap_up();
  end
endmodule : ddr3_bank_burst_selfrefresh_tb

`default_nettype wire

// file: tb/ddr3_ctrl_model.sv
// Controller-side model: turns one bench request into one command handshake.
// Assumes the same clk as the block and a bench that waits for req_done.
`timescale 1ns/1ps
`default_nettype none

module ddr3_ctrl_model #(
  parameter bit ASR_SUPPORTED = 1'b1
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              req_valid,
  input  wire ddr3_pkg::cmd_type req,
  output var  logic              req_done,
  output var  logic              cmd_valid,
  input  wire logic              cmd_ready,
  output var  ddr3_pkg::cmd_type cmd
);
  ddr3_pkg::cmd_type fixed;

  always_comb
  begin
    fixed = req;
    if (req.op == ddr3_pkg::OP_MRS && req.bank == ddr3_pkg::MR2_SEL)
    begin
      if (!ASR_SUPPORTED)
        fixed.addr[ddr3_pkg::A_AUTO_SR] = 1'b0;
      if (fixed.addr[ddr3_pkg::A_AUTO_SR])
        fixed.addr[ddr3_pkg::A_MANUAL_SRT] = 1'b0;
    end
  end

  // Command held steady until taken, since the block may stall its FIFO
  always_ff @(posedge clk)
  begin
    req_done <= 1'b0;
    if (!rst_n)
      cmd_valid <= 1'b0;
    else if (cmd_valid && cmd_ready)
    begin
      cmd_valid <= 1'b0;
      req_done  <= 1'b1;
      cmd       <= ~cmd;
    end
    else if (req_valid && !cmd_valid && !req_done)
    begin
      cmd_valid <= 1'b1;
      cmd       <= fixed;
    end
  end
endmodule : ddr3_ctrl_model

`default_nettype wire
